/* File: shared/lpc_mem_pkg.sv */
// Shared constants for the low-pin-count memory cycle link.
package lpc_mem_pkg;
    localparam logic [3:0] START_MEM = 4'h0;
    localparam logic [3:0] TURN_CODE = 4'hf;
    localparam logic [3:0] WAIT_CODE = 4'h5;
    localparam logic [3:0] READY_CODE = 4'h0;
    localparam logic [1:0] CYC_MEM = 2'h1;
    localparam int CYC_TYPE_HI = 3;
    localparam int CYC_TYPE_LO = 2;
    localparam int CYC_DIR_BIT = 1;
    localparam logic [3:0] CYC_READ = 4'h4;
    localparam logic [3:0] CYC_WRITE = 4'h6;
    localparam logic [3:0] ADDR_NIBBLES = 4'h8;
    localparam int SPACE_BIT = 23;
    localparam int SEL_HI = 22;
    localparam int SEL_LO = 19;
    localparam int DEC_BITS = 24;
    localparam logic [3:0] WAIT_CLOCKS = 4'h2;
    localparam logic [3:0] MAX_WAIT = 4'hf;
endpackage

/* File: shared/lpc_mem_if.sv */
// Interface joining the bus master and the memory target over the nibble bus.
interface lpc_mem_if;
    logic frame_strobe_pin_n;
    logic [3:0] nib_m_o;
    logic nib_m_oe;
    logic [3:0] nib_t_o;
    logic nib_t_oe;
    logic [3:0] nibble_bus_pins;
    // Wire level: driven value or pulled high when nobody drives.
    assign nibble_bus_pins = nib_m_oe ? nib_m_o : (nib_t_oe ? nib_t_o : 4'hf);
    modport master (output frame_strobe_pin_n, output nib_m_o, output nib_m_oe,
        input nibble_bus_pins);
    modport target (input frame_strobe_pin_n, output nib_t_o, output nib_t_oe,
        input nibble_bus_pins);
endinterface

/* File: core/lpc_mem_target.sv */
// Target end: decodes memory read and write cycles and answers on the nibble bus.
//
// Operation
// - Start nibble taken on last low-strobe clock.
// - Non-zero start nibble is not this cycle.
// - Cycle type bits 3:2 must equal 01b.
// - Other cycle types: release bus, wait standby.
// - Bit 1 is direction, bit 0 ignored.
// - Address is eight nibbles, 32 bits.
// - Top eight address bits are ignored.
// - Bit 23 selects array or register space.
// - Inverted straps must match address bits 22:19.
// - Master sends address nibbles most significant first.
// - Turn-around: drive 1111b, then release.
// - Wait code while busy, ready code once.
// - Read inserts wait clocks per access time.
// - Reset leaves device in array-read mode.
// - Read opens with 0000b then 010xb.
// - Device takes bus after master turn-around.
// - Ready, then data low nibble, high nibble.
// - After read data, 1111b then release.
// - Write opens with 0000b then 011xb.
// - Master sends write byte low nibble first.
// - Write: one ready code, then turn-around.
// - Fields sampled on rising clock edge.
module lpc_mem_target (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Bus side
    lpc_mem_if.target bus,
    // Straps
    input wire logic [3:0] select_strap_inputs,
    // Memory side
    output logic mem_wr_q,
    output logic mem_rd_q,
    output logic mem_array_q,
    output logic [23:0] mem_addr_q,
    output logic [7:0] mem_wdata_q,
    input wire logic [7:0] mem_rdata,
    input wire logic mem_ready,
    output logic array_read_mode_q,
    output logic standby_q
);
    typedef enum logic [3:0] {
        ST_IDLE = 4'h0, ST_START = 4'h1, ST_ADDR = 4'h3,
        ST_WDATA = 4'h4, ST_MTAR0 = 4'h5, ST_MTAR1 = 4'h6, ST_SYNC = 4'h7,
        ST_DLO = 4'h8, ST_DHI = 4'h9, ST_TTAR0 = 4'ha, ST_TTAR1 = 4'hb,
        ST_SKIP = 4'hc
    } tstate_e;

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    // Two stages on every pin input; the master therefore sees a fixed extra latency.
    logic frame_s1_q, frame_n_q;
    logic [3:0] nib_s1_q, nib_q, strap_s1_q, strap_q;
    logic rdy_s1_q, rdy_q;
    always_ff @(posedge clk_sys) begin
        frame_s1_q <= bus.frame_strobe_pin_n;
        frame_n_q <= frame_s1_q;
        nib_s1_q <= bus.nibble_bus_pins;
        nib_q <= nib_s1_q;
        strap_s1_q <= select_strap_inputs;
        strap_q <= strap_s1_q;
        rdy_s1_q <= mem_ready;
        rdy_q <= rdy_s1_q;
    end

    // ----------------------------------------------------------------
    // Cycle sequencer
    // ----------------------------------------------------------------
    tstate_e state_q;
    logic write_q;
    logic [3:0] cnt_q;
    logic [31:0] addr_q;
    logic [7:0] rdata_q;
    logic [3:0] nib_o_q;
    logic oe_q;
    logic sel_ok;
    logic start_ok_q;
    logic [1:0] cyc_kind;
    assign sel_ok = (~strap_q == addr_q[lpc_mem_pkg::SEL_HI:lpc_mem_pkg::SEL_LO]);
    assign cyc_kind = nib_q[lpc_mem_pkg::CYC_TYPE_HI:lpc_mem_pkg::CYC_TYPE_LO];

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_q <= ST_IDLE;
            write_q <= 1'b0;
            start_ok_q <= 1'b0;
            cnt_q <= 4'h0;
            addr_q <= 32'h0000_0000;
            rdata_q <= 8'h00;
            nib_o_q <= 4'hf;
            oe_q <= 1'b0;
            mem_rd_q <= 1'b0;
            mem_wr_q <= 1'b0;
            mem_array_q <= 1'b0;
            mem_addr_q <= 24'h00_0000;
            mem_wdata_q <= 8'h00;
        end else begin
            mem_rd_q <= 1'b0;
            mem_wr_q <= 1'b0;
            unique case (state_q)
                ST_IDLE, ST_SKIP: begin
                    oe_q <= 1'b0;
                    if (!frame_n_q) begin
                        start_ok_q <= (nib_q == lpc_mem_pkg::START_MEM);
                        state_q <= ST_START;
                    end
                end
                ST_START: begin
                    // The nibble seen while the strobe is still low is a newer start.
                    if (!frame_n_q) begin
                        start_ok_q <= (nib_q == lpc_mem_pkg::START_MEM);
                    end else begin
                        state_q <= ST_SKIP;
                        if (start_ok_q && cyc_kind == lpc_mem_pkg::CYC_MEM) begin
                            state_q <= ST_ADDR;
                            write_q <= nib_q[lpc_mem_pkg::CYC_DIR_BIT];
                            cnt_q <= 4'h1;
                        end
                    end
                end
                ST_ADDR: begin
                    addr_q <= {addr_q[27:0], nib_q};
                    cnt_q <= cnt_q + 4'h1;
                    if (cnt_q == lpc_mem_pkg::ADDR_NIBBLES) begin
                        cnt_q <= 4'h0;
                        state_q <= write_q ? ST_WDATA : ST_MTAR0;
                    end
                end
                ST_WDATA: begin
                    mem_wdata_q <= {nib_q, mem_wdata_q[7:4]};
                    cnt_q <= cnt_q + 4'h1;
                    if (cnt_q == 4'h1) begin
                        state_q <= ST_MTAR0;
                    end
                end
                ST_MTAR0: begin
                    // Straps checked once the full address is in.
                    state_q <= sel_ok ? ST_MTAR1 : ST_SKIP;
                    mem_addr_q <= addr_q[lpc_mem_pkg::DEC_BITS-1:0];
                    mem_array_q <= addr_q[lpc_mem_pkg::SPACE_BIT];
                end
                ST_MTAR1: begin
                    state_q <= ST_SYNC;
                    cnt_q <= 4'h0;
                    mem_rd_q <= ~write_q;
                    mem_wr_q <= write_q;
                end
                ST_SYNC: begin
                    oe_q <= 1'b1;
                    cnt_q <= cnt_q + 4'h1;
                    if (write_q || (cnt_q >= lpc_mem_pkg::WAIT_CLOCKS && rdy_q)) begin
                        nib_o_q <= lpc_mem_pkg::READY_CODE;
                        rdata_q <= mem_rdata;
                        state_q <= write_q ? ST_TTAR0 : ST_DLO;
                    end else begin
                        nib_o_q <= lpc_mem_pkg::WAIT_CODE;
                    end
                end
                ST_DLO: begin
                    nib_o_q <= rdata_q[3:0];
                    state_q <= ST_DHI;
                end
                ST_DHI: begin
                    nib_o_q <= rdata_q[7:4];
                    state_q <= ST_TTAR0;
                end
                ST_TTAR0: begin
                    nib_o_q <= lpc_mem_pkg::TURN_CODE;
                    state_q <= ST_TTAR1;
                end
                ST_TTAR1: begin
                    oe_q <= 1'b0;
                    state_q <= ST_IDLE;
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Mode and standby
    // ----------------------------------------------------------------
    // Command decoding is outside this block, so array-read mode only follows reset.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            array_read_mode_q <= 1'b1;
            standby_q <= 1'b1;
        end else begin
            standby_q <= (state_q == ST_IDLE || state_q == ST_SKIP) && frame_n_q;
        end
    end

    assign bus.nib_t_o = nib_o_q;
    assign bus.nib_t_oe = oe_q;
endmodule

/* File: core/lpc_mem_master.sv */
// Master end: issues one memory read or write cycle per user request.
module lpc_mem_master (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Bus side
    lpc_mem_if.master bus,
    // User request
    input wire logic req,
    input wire logic req_write,
    input wire logic [31:0] req_addr,
    input wire logic [7:0] req_wdata,
    // User answer
    output logic busy_q,
    output logic done_q,
    output logic timeout_q,
    output logic [7:0] rdata_q
);
    typedef enum logic [3:0] {
        M_IDLE = 4'h0, M_START = 4'h1, M_CYC = 4'h2, M_ADDR = 4'h3,
        M_DATA = 4'h4, M_TURNAROUND_FIRST_CLOCK = 4'h5, M_TURNAROUND_SECOND_CLOCK = 4'h6, M_SYNC = 4'h7,
        M_DLO = 4'h8, M_DHI = 4'h9, M_RTAR = 4'ha
    } mstate_e;

    // ----------------------------------------------------------------
    // Pin synchroniser
    // ----------------------------------------------------------------
    logic [3:0] in_s1_q, in_q;
    always_ff @(posedge clk_sys) begin
        in_s1_q <= bus.nibble_bus_pins;
        in_q <= in_s1_q;
    end

    // ----------------------------------------------------------------
    // Cycle sequencer
    // ----------------------------------------------------------------
    mstate_e state_q;
    logic wr_q, frame_q, oe_q;
    logic [3:0] out_q, cnt_q;
    logic [31:0] addr_q;
    logic [7:0] wdata_q;
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_q <= M_IDLE;
            wr_q <= 1'b0;
            frame_q <= 1'b1;
            oe_q <= 1'b0;
            out_q <= 4'hf;
            cnt_q <= 4'h0;
            addr_q <= 32'h0000_0000;
            wdata_q <= 8'h00;
            busy_q <= 1'b0;
            done_q <= 1'b0;
            timeout_q <= 1'b0;
            rdata_q <= 8'h00;
        end else begin
            done_q <= 1'b0;
            unique case (state_q)
                M_IDLE: begin
                    if (req) begin
                        busy_q <= 1'b1;
                        timeout_q <= 1'b0;
                        wr_q <= req_write;
                        addr_q <= req_addr;
                        wdata_q <= req_wdata;
                        frame_q <= 1'b0;
                        oe_q <= 1'b1;
                        out_q <= lpc_mem_pkg::START_MEM;
                        state_q <= M_START;
                    end
                end
                M_START: begin
                    frame_q <= 1'b1;
                    out_q <= req_write_code(wr_q);
                    cnt_q <= 4'h0;
                    state_q <= M_CYC;
                end
                M_CYC, M_ADDR: begin
                    out_q <= addr_q[31:28];
                    addr_q <= {addr_q[27:0], 4'h0};
                    cnt_q <= cnt_q + 4'h1;
                    state_q <= M_ADDR;
                    if (cnt_q == lpc_mem_pkg::ADDR_NIBBLES - 4'h1) begin
                        cnt_q <= 4'h0;
                        state_q <= wr_q ? M_DATA : M_TURNAROUND_FIRST_CLOCK;
                    end
                end
                M_DATA: begin
                    out_q <= wdata_q[3:0];
                    wdata_q <= {4'h0, wdata_q[7:4]};
                    cnt_q <= cnt_q + 4'h1;
                    if (cnt_q == 4'h1) begin
                        state_q <= M_TURNAROUND_FIRST_CLOCK;
                    end
                end
                M_TURNAROUND_FIRST_CLOCK: begin
                    out_q <= lpc_mem_pkg::TURN_CODE;
                    state_q <= M_TURNAROUND_SECOND_CLOCK;
                end
                M_TURNAROUND_SECOND_CLOCK: begin
                    oe_q <= 1'b0;
                    cnt_q <= 4'h0;
                    state_q <= M_SYNC;
                end
                M_SYNC: begin
                    // Bounded wait so a missing target cannot hang the master.
                    cnt_q <= cnt_q + 4'h1;
                    if (in_q == lpc_mem_pkg::READY_CODE && cnt_q > 4'h2) begin
                        state_q <= wr_q ? M_RTAR : M_DLO;
                        cnt_q <= 4'h0;
                    end else if (cnt_q == lpc_mem_pkg::MAX_WAIT) begin
                        timeout_q <= 1'b1;
                        busy_q <= 1'b0;
                        done_q <= 1'b1;
                        state_q <= M_IDLE;
                    end
                end
                M_DLO: begin
                    rdata_q[3:0] <= in_q;
                    state_q <= M_DHI;
                end
                M_DHI: begin
                    rdata_q[7:4] <= in_q;
                    state_q <= M_RTAR;
                end
                M_RTAR: begin
                    cnt_q <= cnt_q + 4'h1;
                    if (cnt_q == 4'h3) begin
                        busy_q <= 1'b0;
                        done_q <= 1'b1;
                        state_q <= M_IDLE;
                    end
                end
                default: begin
                    state_q <= M_IDLE;
                end
            endcase
        end
    end

    function automatic logic [3:0] req_write_code(input logic w);
        req_write_code = w ? lpc_mem_pkg::CYC_WRITE : lpc_mem_pkg::CYC_READ;
    endfunction

    assign bus.frame_strobe_pin_n = frame_q;
    assign bus.nib_m_o = out_q;
    assign bus.nib_m_oe = oe_q;
endmodule

/* File: verification/lpc_mem_link_properties.sv */
// Concurrent checks on the nibble bus joining the master and target ends.
module lpc_mem_link_properties (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Bus signals
    input wire logic frame_strobe_pin_n,
    input wire logic [3:0] nib_m_o,
    input wire logic nib_m_oe,
    input wire logic [3:0] nib_t_o,
    input wire logic nib_t_oe,
    input wire logic [3:0] nibble_bus_pins
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    logic t_oe_q;
    logic waiting_q;
    // A read is told apart from a data nibble of 0101b by an unbroken wait run since takeover.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            t_oe_q <= 1'b0;
            waiting_q <= 1'b0;
        end else begin
            t_oe_q <= nib_t_oe;
            waiting_q <= nib_t_oe && nib_t_o == lpc_mem_pkg::WAIT_CODE && (waiting_q || !t_oe_q);
        end
    end
    property p_no_contend;
        !(nib_m_oe && nib_t_oe);
    endproperty
    a_no_contend: assert property (p_no_contend) else $error("both ends drive");
    property p_frame_start;
        !frame_strobe_pin_n |-> nib_m_oe && nibble_bus_pins == lpc_mem_pkg::START_MEM;
    endproperty
    a_frame_start: assert property (p_frame_start) else $error("bad start nibble");
    property p_type;
        $rose(frame_strobe_pin_n) |-> nib_m_oe && nib_m_o[3:2] == lpc_mem_pkg::CYC_MEM;
    endproperty
    a_type: assert property (p_type) else $error("bad cycle type");
    property p_mtar_rd;
        $rose(frame_strobe_pin_n) && nib_m_o == lpc_mem_pkg::CYC_READ |=> nib_m_oe [*8]
            ##1 (nib_m_oe && nib_m_o == lpc_mem_pkg::TURN_CODE) ##1 !nib_m_oe;
    endproperty
    a_mtar_rd: assert property (p_mtar_rd) else $error("read address or tar");
    property p_mtar_wr;
        $rose(frame_strobe_pin_n) && nib_m_o == lpc_mem_pkg::CYC_WRITE |-> ##9 nib_m_oe [*2]
            ##1 (nib_m_oe && nib_m_o == lpc_mem_pkg::TURN_CODE) ##1 !nib_m_oe;
    endproperty
    a_mtar_wr: assert property (p_mtar_wr) else $error("write data or tar");
    property p_first_sync;
        $rose(nib_t_oe) && nib_t_o != lpc_mem_pkg::READY_CODE |->
            (nib_t_o == lpc_mem_pkg::WAIT_CODE) [*2] ##[1:20] nib_t_o == lpc_mem_pkg::READY_CODE;
    endproperty
    a_first_sync: assert property (p_first_sync) else $error("wait run wrong");
    property p_read_tail;
        waiting_q && nib_t_oe && nib_t_o == lpc_mem_pkg::READY_CODE |->
            ##3 (nib_t_oe && nib_t_o == lpc_mem_pkg::TURN_CODE) ##1 !nib_t_oe;
    endproperty
    a_read_tail: assert property (p_read_tail) else $error("read tail wrong");
    property p_write_tail;
        $rose(nib_t_oe) && nib_t_o == lpc_mem_pkg::READY_CODE |=>
            (nib_t_oe && nib_t_o == lpc_mem_pkg::TURN_CODE) ##1 !nib_t_oe;
    endproperty
    a_write_tail: assert property (p_write_tail) else $error("write tail wrong");
endmodule

/* File: verification/lpc_memory_cycle_target_tb.sv */
// Self-checking bench joining the master and target ends over the nibble bus.
module lpc_memory_cycle_target_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic req, req_write, busy_q, done_q, timeout_q, mem_wr_q, mem_rd_q, mem_array_q;
    logic array_read_mode_q, standby_q, mem_ready;
    logic [31:0] req_addr;
    logic [7:0] req_wdata, rdata_q, mem_wdata_q, mem_rdata, wr_data;
    logic [23:0] mem_addr_q;
    logic [24:0] wr_key, rd_key;
    logic [3:0] strap;
    logic [3:0] trace[$];
    logic [7:0] mem[logic [24:0]];
    int fails = 0;
    int check_count = 0;
    int wr_cnt = 0;
    int rd_cnt = 0;
    always #5 clk_sys = ~clk_sys;
    lpc_mem_if bus_if();
    lpc_mem_master i_lpc_mem_master (.clk_sys(clk_sys), .rst(rst), .bus(bus_if), .req(req),
        .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata), .busy_q(busy_q),
        .done_q(done_q), .timeout_q(timeout_q), .rdata_q(rdata_q));
    lpc_mem_target i_lpc_mem_target (.clk_sys(clk_sys), .rst(rst), .bus(bus_if),
        .select_strap_inputs(strap), .mem_wr_q(mem_wr_q), .mem_rd_q(mem_rd_q),
        .mem_array_q(mem_array_q), .mem_addr_q(mem_addr_q), .mem_wdata_q(mem_wdata_q),
        .mem_rdata(mem_rdata), .mem_ready(mem_ready), .array_read_mode_q(array_read_mode_q),
        .standby_q(standby_q));
    lpc_mem_link_properties i_lpc_mem_link_properties (.clk_sys(clk_sys), .rst(rst),
        .frame_strobe_pin_n(bus_if.frame_strobe_pin_n), .nib_m_o(bus_if.nib_m_o),
        .nib_m_oe(bus_if.nib_m_oe), .nib_t_o(bus_if.nib_t_o), .nib_t_oe(bus_if.nib_t_oe),
        .nibble_bus_pins(bus_if.nibble_bus_pins));
    // --------------------------------------------------
    // Memory stub and bus trace
    // --------------------------------------------------
    // Unwritten places read back a pattern of their own key, so a wrong key shows.
    function automatic logic [7:0] stored(input logic [24:0] k);
        return mem.exists(k) ? mem[k] : k[7:0] ^ k[15:8];
    endfunction
    always @(negedge clk_sys) mem_rdata <= stored({mem_array_q, mem_addr_q});
    always @(posedge clk_sys) begin
        if (mem_wr_q === 1'b1) begin
            wr_cnt++;
            wr_key = {mem_array_q, mem_addr_q};
            wr_data = mem_wdata_q;
            mem[wr_key] = mem_wdata_q;
        end
        if (mem_rd_q === 1'b1) begin
            rd_cnt++;
            rd_key = {mem_array_q, mem_addr_q};
        end
        if (bus_if.frame_strobe_pin_n === 1'b0) begin
            trace.delete();
            trace.push_back(bus_if.nibble_bus_pins);
        end else if (busy_q === 1'b1) begin
            trace.push_back(bus_if.nibble_bus_pins);
        end
    end
    // --------------------------------------------------
    // Tasks
    // --------------------------------------------------
    task automatic report_and_stop();
        if (fails == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic run_cycle(input logic wr, input logic [31:0] a, input logic [7:0] d);
        logic hit;
        logic [24:0] k;
        int w0, r0, n, j;
        hit = (~strap == a[22:19]);
        k = {a[23], a[23:0]};
        w0 = wr_cnt;
        r0 = rd_cnt;
        n = 0;
        @(negedge clk_sys);
        req = 1'b1;
        req_write = wr;
        req_addr = a;
        req_wdata = d;
        while (busy_q !== 1'b1 && n < 20) begin @(negedge clk_sys); n++; end
        if (busy_q !== 1'b1) n = 200;
        req = 1'b0;
        repeat (4) @(negedge clk_sys);
        chk("standby_busy", 32'h0000_0000, 32'(standby_q));
        while (busy_q === 1'b1 && n < 200) begin @(negedge clk_sys); n++; end
        if (n >= 200) begin fails++; report_and_stop(); end
        chk("done", 32'h0000_0001, 32'(done_q));
        chk("standby", 32'h0000_0001, 32'(standby_q));
        chk("timeout", 32'(!hit), 32'(timeout_q));
        chk("wr_count", 32'(wr && hit), 32'(wr_cnt - w0));
        chk("rd_count", 32'(!wr && hit), 32'(rd_cnt - r0));
        chk("start", 32'(lpc_mem_pkg::START_MEM), 32'(trace[0]));
        chk("type", wr ? 32'h0000_0006 : 32'h0000_0004, 32'(trace[1]));
        for (j = 0; j < 8; j++) chk("addr", 32'(a[31 - 4 * j -: 4]), 32'(trace[2 + j]));
        if (wr) chk("wdata", 32'(d), {24'h0, trace[11], trace[10]});
        chk("tar", 32'(lpc_mem_pkg::TURN_CODE), 32'(trace[wr ? 12 : 10]));
        if (hit) begin
            if (wr) chk("wr_key", 32'(k), 32'(wr_key));
            if (wr) chk("wr_data", 32'(d), 32'(wr_data));
            if (!wr) chk("rd_key", 32'(k), 32'(rd_key));
            if (!wr) chk("rdata", 32'(stored(k)), 32'(rdata_q));
            j = wr ? 14 : 12;
            while (j < trace.size() && (trace[j] == 4'hf || trace[j] == 4'h5)) j++;
            chk("ready", 32'(lpc_mem_pkg::READY_CODE), 32'(trace[j]));
            if (!wr) chk("data", 32'(stored(k)), {24'h0, trace[j + 2], trace[j + 1]});
            chk("tail", 32'(lpc_mem_pkg::TURN_CODE), 32'(trace[wr ? j + 1 : j + 3]));
        end
    endtask
    initial begin
        logic [31:0] a;
        void'($urandom(32'hd4793b8f));
        {req, req_write, req_addr, req_wdata} = '0;
        strap = 4'h3;
        mem_ready = 1'b1;
        repeat (4) @(negedge clk_sys);
        rst = 1'b0;
        @(negedge clk_sys);
        chk("array_mode", 32'h0000_0001, 32'(array_read_mode_q));
        chk("standby", 32'h0000_0001, 32'(standby_q));
        for (int i = 0; i < 12; i++) begin
            strap = 4'($urandom);
            a = $urandom;
            if (i % 4 != 3) a[22:19] = ~strap;
            run_cycle(1'b1, a, 8'($urandom));
            run_cycle(1'b0, a, 8'h00);
            a[31:24] = ~a[31:24];
            run_cycle(1'b0, a, 8'h00);
        end
        // Slow memory: ready comes late, so the target must stretch its wait run.
        mem_ready = 1'b0;
        fork
            begin repeat (22) @(negedge clk_sys); mem_ready = 1'b1; end
        join_none
        run_cycle(1'b0, {8'h00, 1'b1, ~strap, 19'h0_1234}, 8'h00);
        report_and_stop();
    end
endmodule
